//--- verilog/supervisor_pkg.sv
// constants shared by the supervisor timing block
`default_nettype none
package supervisor_pkg;
  // apb register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h0c;
  // ctrl fields
  localparam int WD_SEL_LSB = 0;
  localparam int REL_SEL_LSB = 2;
  localparam logic [1:0] WD_SEL_RESET = 2'h0;
  localparam logic [1:0] REL_SEL_RESET = 2'h0;
  // status fields
  localparam int ST_RESET_BIT = 0;
  localparam int ST_WD_BIT = 1;
  localparam int ST_SECOND_BIT = 2;
  localparam int ST_PRIMARY_BIT = 3;
  // interrupt event bits
  localparam int EV_WD_BIT = 0;
  localparam int EV_DROP_BIT = 1;
  localparam int EV_SECOND_BIT = 2;
  localparam int EV_W = 3;
  localparam logic [EV_W-1:0] IRQ_MASK_RESET = 3'h0;
  // time base
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  // watchdog periods in ms ticks
  localparam int WD_P0_MS = 25;
  localparam int WD_P1_MS = 200;
  localparam int WD_P2_MS = 1400;
  // reset release delays in ms ticks
  localparam int REL_P0_MS = 50;
  localparam int REL_P1_MS = 200;
  localparam int REL_P2_MS = 400;
  localparam int REL_P3_MS = 800;
  localparam int CNT_W = 11;
  typedef enum logic [1:0] {
    WD_25MS = 2'b00,
    WD_200MS = 2'b01,
    WD_1400MS = 2'b10,
    WD_OFF = 2'b11
  } wd_sel_t;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ARMED = 2'b01
  } restart_state_t;
endpackage
`default_nettype wire

//--- verilog/cpu_supervisor_timing.sv
// supervisor timing: power-on reset release, watchdog, secondary fail
//
// Chosen here: the APB slave port and the placing of the registers.
`default_nettype none
module cpu_supervisor_timing #(
  parameter int TICK_COUNT = supervisor_pkg::TICK_CYCLES,
  parameter bit RESET_ACTIVE_HIGH = 1'b1
) (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_primary_above_trip,
  input wire logic i_second_supply_sense_in,
  output logic o_sys_reset,
  output logic o_sys_reset_oe_n,
  output logic o_watchdog_fault_out,
  output logic o_watchdog_fault_oe_n,
  output logic o_second_supply_fail_out,
  output logic o_second_supply_fail_oe_n,
  output logic o_mem_bus_enable,
  output logic o_irq
);
  import supervisor_pkg::*;

  function automatic logic [CNT_W-1:0] wd_limit(input logic [1:0] sel);
    logic [CNT_W-1:0] lim;
    lim = CNT_W'(WD_P2_MS);
    unique case (sel)
      WD_25MS: lim = CNT_W'(WD_P0_MS);
      WD_200MS: lim = CNT_W'(WD_P1_MS);
      WD_1400MS: lim = CNT_W'(WD_P2_MS);
      WD_OFF: lim = CNT_W'(WD_P2_MS);
    endcase
    return lim;
  endfunction

  function automatic logic [CNT_W-1:0] rel_limit(input logic [1:0] sel);
    logic [CNT_W-1:0] lim;
    lim = CNT_W'(REL_P0_MS);
    unique case (sel)
      2'b00: lim = CNT_W'(REL_P0_MS);
      2'b01: lim = CNT_W'(REL_P1_MS);
      2'b10: lim = CNT_W'(REL_P2_MS);
      2'b11: lim = CNT_W'(REL_P3_MS);
    endcase
    return lim;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [1:0] scl_sync_ff;
  logic [1:0] sda_sync_ff;
  logic [1:0] prim_sync_ff;
  logic [1:0] sec_sync_ff;
  logic scl_d_ff;
  logic sda_d_ff;

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      scl_sync_ff <= 2'h3;
      sda_sync_ff <= 2'h3;
      prim_sync_ff <= 2'h0;
      // idle as above trip, matching the fail flag's reset: no false fail
      sec_sync_ff <= 2'h3;
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_sync_ff <= {scl_sync_ff[0], i_scl};
      // sda sampled unconditionally, bus state never blocks it
      sda_sync_ff <= {sda_sync_ff[0], i_sda};
      prim_sync_ff <= {prim_sync_ff[0], i_primary_above_trip};
      sec_sync_ff <= {sec_sync_ff[0], i_second_supply_sense_in};
      scl_d_ff <= scl_sync_ff[1];
      sda_d_ff <= sda_sync_ff[1];
    end
  end

  wire scl_s = scl_sync_ff[1];
  wire sda_s = sda_sync_ff[1];
  wire primary_ok = prim_sync_ff[1];
  wire second_ok = sec_sync_ff[1];
  // data edges while clock high and steady
  wire scl_hold = scl_s & scl_d_ff;
  wire start_det = scl_hold & sda_d_ff & ~sda_s;
  wire stop_det = scl_hold & ~sda_d_ff & sda_s;

  ////////////////////////////////////////////////////////////////////
  // registers and apb slave
  logic [1:0] wd_sel_ff;
  logic [1:0] rel_sel_ff;
  logic [EV_W-1:0] irq_stat_ff;
  logic [EV_W-1:0] irq_mask_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;

  wire access = i_psel & i_penable & ~pready_ff;
  wire [7:0] ofs = i_paddr[7:0];
  wire hit_ctrl = (ofs == CTRL_OFS);
  wire hit_status = (ofs == STATUS_OFS);
  wire hit_istat = (ofs == IRQ_STAT_OFS);
  wire hit_imask = (ofs == IRQ_MASK_OFS);
  wire mapped = (i_paddr[31:8] == 24'h000000) & (hit_ctrl | hit_status | hit_istat | hit_imask);
  wire wr_ok = access & i_pwrite & mapped;
  wire wr_ctrl = wr_ok & hit_ctrl;
  wire wr_istat = wr_ok & hit_istat;
  wire wr_imask = wr_ok & hit_imask;

  logic reset_active_ff;
  logic wd_expired_ff;
  logic second_fail_ff;

  wire [31:0] ctrl_word = {28'h0000000, rel_sel_ff, wd_sel_ff};
  // status bits placed by their named positions
  logic [31:0] status_word;
  always_comb begin
    status_word = 32'h00000000;
    status_word[ST_RESET_BIT] = reset_active_ff;
    status_word[ST_WD_BIT] = wd_expired_ff;
    status_word[ST_SECOND_BIT] = second_fail_ff;
    status_word[ST_PRIMARY_BIT] = primary_ok;
  end
  wire [31:0] istat_word = {29'h00000000, irq_stat_ff};
  wire [31:0] imask_word = {29'h00000000, irq_mask_ff};
  wire [31:0] rd_word = hit_ctrl ? ctrl_word :
                        hit_status ? status_word :
                        hit_istat ? istat_word :
                        hit_imask ? imask_word : 32'h00000000;
  wire [31:0] nxt_prdata = (access & ~i_pwrite & mapped) ? rd_word : 32'h00000000;

  // select bits live apart from supply state: only i_reset_n or a host
  // write moves them, so a primary supply loss leaves them intact
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wd_sel_ff <= WD_SEL_RESET;
      rel_sel_ff <= REL_SEL_RESET;
    end else if (wr_ctrl) begin
      wd_sel_ff <= i_pwdata[WD_SEL_LSB+1:WD_SEL_LSB];
      rel_sel_ff <= i_pwdata[REL_SEL_LSB+1:REL_SEL_LSB];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
    end else begin
      pready_ff <= access;
      pslverr_ff <= access & ~mapped;
      prdata_ff <= nxt_prdata;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // millisecond time base; free running, so each count has up to one
  // tick of phase slack, traded for a single shared prescaler
  logic [16:0] tick_cnt_ff;
  logic tick_ff;
  wire tick_wrap = (tick_cnt_ff == 17'(TICK_COUNT - 1));

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tick_cnt_ff <= 17'h00000;
      tick_ff <= 1'b0;
    end else begin
      tick_cnt_ff <= tick_wrap ? 17'h00000 : tick_cnt_ff + 17'h00001;
      tick_ff <= tick_wrap;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // reset release timer
  logic [CNT_W-1:0] rel_cnt_ff;
  wire rel_done = (rel_cnt_ff >= rel_limit(rel_sel_ff));
  logic [CNT_W-1:0] nxt_rel_cnt;
  logic nxt_reset_active;

  always_comb begin
    nxt_rel_cnt = rel_cnt_ff;
    nxt_reset_active = reset_active_ff;
    if (!primary_ok) begin
      nxt_rel_cnt = '0;
      nxt_reset_active = 1'b1;
    end else if (rel_done) begin
      nxt_reset_active = 1'b0;
    end else if (tick_ff) begin
      nxt_rel_cnt = rel_cnt_ff + CNT_W'(1);
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rel_cnt_ff <= '0;
      reset_active_ff <= 1'b1;
    end else begin
      rel_cnt_ff <= nxt_rel_cnt;
      reset_active_ff <= nxt_reset_active;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // watchdog restart detector and counter
  restart_state_t rs_state_ff;
  restart_state_t nxt_rs_state;
  logic [CNT_W-1:0] wd_cnt_ff;
  logic [CNT_W-1:0] nxt_wd_cnt;
  logic nxt_wd_expired;
  logic restart;

  always_comb begin
    nxt_rs_state = rs_state_ff;
    restart = 1'b0;
    unique case (rs_state_ff)
      BUS_IDLE: begin
        if (start_det) begin
          nxt_rs_state = BUS_ARMED;
        end
      end
      BUS_ARMED: begin
        if (stop_det) begin
          restart = 1'b1;
          nxt_rs_state = BUS_IDLE;
        end
      end
      default: nxt_rs_state = BUS_IDLE;
    endcase
  end

  wire wd_off = (wd_sel_ff == WD_OFF);
  wire wd_hit = (wd_cnt_ff >= wd_limit(wd_sel_ff));

  always_comb begin
    nxt_wd_cnt = wd_cnt_ff;
    nxt_wd_expired = wd_expired_ff;
    if (wd_off) begin
      nxt_wd_cnt = '0;
      nxt_wd_expired = 1'b0;
    end else if (restart) begin
      nxt_wd_cnt = '0;
      nxt_wd_expired = 1'b0;
    end else if (wd_hit) begin
      nxt_wd_expired = 1'b1;
    end else if (tick_ff) begin
      nxt_wd_cnt = wd_cnt_ff + CNT_W'(1);
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rs_state_ff <= BUS_IDLE;
      wd_cnt_ff <= '0;
      wd_expired_ff <= 1'b0;
    end else begin
      rs_state_ff <= nxt_rs_state;
      wd_cnt_ff <= nxt_wd_cnt;
      wd_expired_ff <= nxt_wd_expired;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // interrupt events; a set in the clear cycle wins
  logic second_fail_d_ff;
  wire ev_wd = nxt_wd_expired & ~wd_expired_ff;
  // a drop is news only while released; one cycle, as reset follows
  wire ev_drop = ~primary_ok & ~reset_active_ff;
  wire ev_second = second_fail_ff & ~second_fail_d_ff;
  logic [EV_W-1:0] events;
  always_comb begin
    events = '0;
    events[EV_WD_BIT] = ev_wd;
    events[EV_DROP_BIT] = ev_drop;
    events[EV_SECOND_BIT] = ev_second;
  end
  wire [EV_W-1:0] w1c = wr_istat ? i_pwdata[EV_W-1:0] : '0;
  wire [EV_W-1:0] nxt_irq_stat = (irq_stat_ff & ~w1c) | events;

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      irq_stat_ff <= '0;
      irq_mask_ff <= IRQ_MASK_RESET;
      second_fail_d_ff <= 1'b0;
      o_irq <= 1'b0;
    end else begin
      irq_stat_ff <= nxt_irq_stat;
      irq_mask_ff <= wr_imask ? i_pwdata[EV_W-1:0] : irq_mask_ff;
      second_fail_d_ff <= second_fail_ff;
      o_irq <= |(nxt_irq_stat & irq_mask_ff);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // output pins, all registered
  wire nxt_sys_reset = RESET_ACTIVE_HIGH ? nxt_reset_active : ~nxt_reset_active;
  // push-pull variant drives always; open-drain one only pulls low
  wire nxt_sys_reset_oe_n = RESET_ACTIVE_HIGH ? 1'b0 : ~nxt_reset_active;

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      second_fail_ff <= 1'b0;
      o_sys_reset <= RESET_ACTIVE_HIGH;
      o_sys_reset_oe_n <= RESET_ACTIVE_HIGH ? 1'b0 : 1'b0;
      o_watchdog_fault_out <= 1'b0;
      o_watchdog_fault_oe_n <= 1'b1;
      o_second_supply_fail_out <= 1'b0;
      o_second_supply_fail_oe_n <= 1'b1;
      o_mem_bus_enable <= 1'b0;
    end else begin
      second_fail_ff <= ~second_ok;
      o_sys_reset <= nxt_sys_reset;
      o_sys_reset_oe_n <= nxt_sys_reset_oe_n;
      o_watchdog_fault_out <= 1'b0;
      o_watchdog_fault_oe_n <= ~nxt_wd_expired;
      o_second_supply_fail_out <= 1'b0;
      o_second_supply_fail_oe_n <= second_ok;
      o_mem_bus_enable <= ~nxt_reset_active;
    end
  end

  assign o_prdata = prdata_ff;
  assign o_pready = pready_ff;
  assign o_pslverr = pslverr_ff;
endmodule
`default_nettype wire

//--- tb/sup_bus_master.sv
// two-wire bus master model: start and stop conditions for the watchdog
`default_nettype none
module sup_bus_master (
  input wire logic i_clk,
  output logic o_scl,
  output logic o_sda
);
  timeunit 1ns;
  timeprecision 1ps;
  // each level is held this many cycles plus one; raise it for a slow master
  int hold = 4;
  // released lines sit at the pull-up level
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task automatic step(input logic c, input logic d);
    @(posedge i_clk);
    o_scl <= c;
    o_sda <= d;
    repeat (hold) @(posedge i_clk);
  endtask
  // data falls while clock high, then clock falls
  task automatic start_cond();
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
  endtask
  // data pulses high while clock low, then clock rises, then data rises while clock high
  task automatic stop_cond();
    step(1'b0, 1'b1);
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask
  task automatic kick();
    start_cond();
    stop_cond();
  endtask
endmodule
`default_nettype wire

//--- tb/cpu_supervisor_timing_assertions.sv
// concurrent checks on the supervisor timing ports
`default_nettype none
module cpu_supervisor_timing_assertions #(
  parameter int TICK_COUNT = 10
) (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_primary_above_trip,
  input wire logic i_second_supply_sense_in,
  input wire logic o_sys_reset,
  input wire logic o_watchdog_fault_out,
  input wire logic o_watchdog_fault_oe_n,
  input wire logic o_second_supply_fail_out,
  input wire logic o_second_supply_fail_oe_n,
  input wire logic o_mem_bus_enable
);
  // shortest delay minus one prescaler tick, as the prescaler runs free
  localparam int MIN_HI = (supervisor_pkg::REL_P0_MS - 1) * TICK_COUNT;
  int hi_cnt;
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      hi_cnt <= 0;
    end else begin
      hi_cnt <= i_primary_above_trip ? hi_cnt + 1 : 0;
    end
  end
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_reset_n);
  sequence start_s;
    i_scl && $fell(i_sda);
  endsequence
  sequence stop_s;
    i_scl && $rose(i_sda);
  endsequence
  answer_a: assert property (i_psel && i_penable && !o_pready |=> o_pready)
    else $error("apb access not answered");
  pulse_a: assert property (o_pready |=> !o_pready)
    else $error("ready longer than one cycle");
  err_a: assert property (o_pslverr |-> o_pready)
    else $error("error without ready");
  mem_refuse_a: assert property (o_mem_bus_enable |-> !o_sys_reset)
    else $error("memory bus open during reset");
  drop_a: assert property ($fell(i_primary_above_trip) |-> ##[1:5] o_sys_reset)
    else $error("reset not reasserted on drop");
  hold_a: assert property ($fell(o_sys_reset) |-> hi_cnt >= MIN_HI)
    else $error("reset released early");
  pin_low_a: assert property (!o_watchdog_fault_out && !o_second_supply_fail_out)
    else $error("open drain value not low");
  fail_on_a: assert property ($fell(i_second_supply_sense_in) |-> ##[1:5] !o_second_supply_fail_oe_n)
    else $error("secondary fail late");
  fail_off_a: assert property ($rose(i_second_supply_sense_in) |-> ##[1:5] o_second_supply_fail_oe_n)
    else $error("secondary fail not released");
  kick_a: assert property (start_s ##[1:300] stop_s |-> ##[1:6] o_watchdog_fault_oe_n)
    else $error("restart did not clear fault");
endmodule
bind cpu_supervisor_timing cpu_supervisor_timing_assertions #(
  .TICK_COUNT(TICK_COUNT)
) cpu_supervisor_timing_assertions_i (
  .i_core_clk, .i_reset_n, .i_psel, .i_penable, .o_pready, .o_pslverr, .i_scl, .i_sda,
  .i_primary_above_trip, .i_second_supply_sense_in, .o_sys_reset, .o_watchdog_fault_out,
  .o_watchdog_fault_oe_n, .o_second_supply_fail_out, .o_second_supply_fail_oe_n,
  .o_mem_bus_enable
);
`default_nettype wire

//--- tb/test_cpu_supervisor_timing.sv
// self-checking bench for the supervisor timing block
`default_nettype none
module test_cpu_supervisor_timing;
  import supervisor_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int T = 10;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic pri = 1'b1, sen = 1'b1, pready, pslverr, scl, sda, sys_rst, fault_oe_n;
  logic sec_oe_n, mem_en, irq, ev, sys_oe_n;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rv;
  int n_errors = 0, checks_done = 0, n;
  cpu_supervisor_timing #(.TICK_COUNT(T), .RESET_ACTIVE_HIGH(1'b1)) cpu_supervisor_timing_i (
    .i_core_clk(clk), .i_reset_n(rst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_scl(scl), .i_sda(sda),
    .i_primary_above_trip(pri), .i_second_supply_sense_in(sen), .o_sys_reset(sys_rst),
    .o_sys_reset_oe_n(sys_oe_n), .o_watchdog_fault_out(), .o_watchdog_fault_oe_n(fault_oe_n),
    .o_second_supply_fail_out(), .o_second_supply_fail_oe_n(sec_oe_n),
    .o_mem_bus_enable(mem_en), .o_irq(irq)
  );
  sup_bus_master sup_bus_master_i (.i_clk(clk), .o_scl(scl), .o_sda(sda));
  initial begin
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  // apb master: holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // no cycle count assumed: only the bench watchdog ends this wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_rel();
    n = 0;
    while (sys_rst !== 1'b0 && n < 20000) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic in_win(input int p, input string m);
    chk(n >= (p - 1) * T && n <= (p + 1) * T + 12, 1, m);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_power();
    wait_rel();
    in_win(REL_P0_MS, "first release");
    repeat (2) @(posedge clk);
    chk(mem_en, 1, "mem bus open");
    chk(sys_oe_n, 0, "push-pull reset drives");
    apb(1'b0, IRQ_STAT_OFS, 32'h0);
    chk(rv[EV_SECOND_BIT], 0, "no false secondary event");
    apb(1'b0, CTRL_OFS, 32'h0);
    chk(rv[3:0], {REL_SEL_RESET, WD_SEL_RESET}, "ctrl reset");
    apb(1'b0, 8'h10, 32'h0);
    chk(ev, 1, "unmapped");
    apb(1'b1, CTRL_OFS, 32'h5);
    apb(1'b0, CTRL_OFS, 32'h0);
    chk(rv[3:0], 4'h5, "ctrl rw");
    $display("power test done");
  endtask
  task automatic t_drop();
    apb(1'b1, IRQ_MASK_OFS, 32'h0);
    apb(1'b1, IRQ_STAT_OFS, 32'h7);
    pri <= 1'b0;
    repeat (5) @(posedge clk);
    chk(sys_rst, 1, "drop reset");
    chk(mem_en, 0, "mem refused");
    apb(1'b0, STATUS_OFS, 32'h0);
    chk(rv, (32'h1 << ST_RESET_BIT) | (32'h1 << ST_WD_BIT), "status in reset");
    apb(1'b0, IRQ_STAT_OFS, 32'h0);
    chk(rv[EV_DROP_BIT], 1, "drop event");
    chk(irq, 0, "masked irq");
    apb(1'b1, IRQ_MASK_OFS, 32'h2);
    repeat (2) @(posedge clk);
    chk(irq, 1, "irq raised");
    apb(1'b1, IRQ_STAT_OFS, 32'h2);
    repeat (2) @(posedge clk);
    chk(irq, 0, "irq cleared");
    pri <= 1'b1;
    repeat (100 * T) @(posedge clk);
    pri <= 1'b0;
    repeat (20) @(posedge clk);
    chk(sys_rst, 1, "dip holds reset");
    pri <= 1'b1;
    wait_rel();
    in_win(REL_P1_MS, "release after dip");
    apb(1'b0, CTRL_OFS, 32'h0);
    chk(rv[3:0], 4'h5, "select kept");
    $display("drop test done");
  endtask
  task automatic t_wdog();
    int p[3] = '{WD_P0_MS, WD_P1_MS, WD_P2_MS};
    apb(1'b1, CTRL_OFS, 32'h4);
    repeat (3) begin
      sup_bus_master_i.kick();
      repeat (18 * T) @(posedge clk);
      chk(fault_oe_n, 1, "kept alive");
    end
    for (int s = 0; s < 3; s++) begin
      apb(1'b1, CTRL_OFS, 32'h4 | s);
      sup_bus_master_i.kick();
      repeat (4) @(posedge clk);
      n = 4;
      while (fault_oe_n !== 1'b0 && n < 20000) begin
        @(posedge clk);
        n++;
      end
      in_win(p[s], "expiry");
    end
    sup_bus_master_i.stop_cond();
    repeat (10) @(posedge clk);
    chk(fault_oe_n, 0, "lone stop");
    sup_bus_master_i.hold = 20;
    sup_bus_master_i.kick();
    sup_bus_master_i.hold = 4;
    repeat (10) @(posedge clk);
    chk(fault_oe_n, 1, "slow kick");
    apb(1'b1, CTRL_OFS, 32'h7);
    sup_bus_master_i.kick();
    repeat (1500 * T) @(posedge clk);
    chk(fault_oe_n, 1, "watchdog off");
    $display("watchdog test done");
  endtask
  task automatic t_second();
    sen <= 1'b0;
    repeat (5) @(posedge clk);
    chk(sec_oe_n, 0, "secondary low");
    sen <= 1'b1;
    repeat (5) @(posedge clk);
    chk(sec_oe_n, 1, "secondary high");
    $display("secondary test done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // run needs about 36k cycles; allow margin
  initial begin
    #800000;
    n_errors++;
    end_of_test();
  end
  initial begin
    repeat (5) @(posedge clk);
    chk(sys_rst, 1, "reset at power-up");
    chk(mem_en, 0, "mem refused at power-up");
    rst_n <= 1'b1;
    t_power();
    t_drop();
    t_wdog();
    t_second();
    end_of_test();
  end
endmodule
`default_nettype wire
